// file: rtl/sbdp_pkg.sv
// Shared constants and carrier types of the system bus data-phase control
package sbdp_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 8;
    localparam int unsigned BCLK_PERIOD_NS = 80;
    // Local clocks per bus clock, rounded down
    localparam int unsigned BCLK_CYC       = BCLK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [3:0]  PHASE_MAX      = 4'hf;
    localparam logic [3:0]  STB_FALL_CYC   = 4'h2;
    localparam logic [3:0]  STB_RISE_CYC   = 4'h6;
    localparam int unsigned GROUPS         = 4;
    localparam int unsigned GROUP_W        = 16;
    localparam int unsigned DATA_W         = 64;
    localparam logic [4:0]  INV_LIMIT      = 5'h08;
    localparam int unsigned BUF_DEPTH      = 2;
    localparam logic [3:0]  MASK_FULL      = 4'hf;
    localparam logic [3:0]  MASK_NONE      = 4'h0;
    localparam logic        PIN_IDLE       = 1'b1;

    // Electrical pin levels, all active low
    typedef struct packed {
        logic [DATA_W-1:0] data_n;
        logic [3:0]        group_inversion_bits_n;
        logic [3:0]        negative_data_strobes_n;
        logic [3:0]        positive_data_strobes_n;
        logic              data_valid_handshake_n;
        logic              data_bus_owned_n;
    } sbdp_pins_t;

    typedef struct packed {
        logic              last;
        logic [DATA_W-1:0] data;
    } sbdp_word_t;

    localparam sbdp_pins_t PINS_IDLE = '{default: '1};

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_OWN  = 2'b01,
        TX_DATA = 2'b10,
        TX_DONE = 2'b11
    } sbdp_tx_state_t;
endpackage : sbdp_pkg

// file: rtl/sbdp_buf.sv
// Two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ns
module sbdp_buf
    import sbdp_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Fill side
    input  wire logic       in_valid_i,
    output logic            in_ready_o,
    input  wire sbdp_word_t in_data_i,
    // Drain side
    output logic            out_valid_o,
    input  wire logic       out_ready_i,
    output sbdp_word_t      out_data_o
);
    sbdp_word_t mem [BUF_DEPTH];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] count;
    logic [1:0] next_count;
    logic       push;
    logic       pop;

    assign push = in_valid_i & in_ready_o;
    assign pop  = out_valid_o & out_ready_i;
    assign next_count = count + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
            // Ready is registered so the top's ready output comes from a flop
            in_ready_o <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count      <= next_count;
            in_ready_o <= (next_count != 2'h2);
        end
    end

    // Entries are registers; read data come from them through a 2:1 mux on rd_ptr
    assign out_data_o  = mem[rd_ptr];
    assign out_valid_o = (count != 2'h0);

    buf_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
        count <= 2'h2) else $error("buffer count above depth");
endmodule : sbdp_buf

// file: rtl/sbdp_ctrl.sv
// Data-phase control: deferral, data-ready handshake, strobed data with inversion
`timescale 1ns/1ns
// Functional notes
// R1: Asserted deferral marks the current transaction as possibly completing out of order.
// R2: The addressed memory or I/O agent normally drives the deferral signal.
// R3: The data driver asserts data-ready on every data transfer it makes.
// R4: Driver may idle with data-ready off; receiver takes nothing then.
// R5: Four negative strobes latch 64 data lines, one 16-bit group and inversion bit each.
// R6: Data latched on falling edges of both positive and negative strobes.
// R7: Group inverted when over half would be low; inversion bit set; receiver re-inverts.
// R8: Data driver holds bus-busy while owning data bus; released when it drops.
module sbdp_ctrl
    import sbdp_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Bus clock and deferral pins
    input  wire logic       bus_clk_i,
    input  wire logic       out_of_order_indication_n_i,
    // Shared data-phase pins
    input  wire sbdp_pins_t pins_i,
    output sbdp_pins_t      pins_o,
    output logic            pins_oe_o,
    // Words to send
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o,
    input  wire sbdp_word_t tx_word_i,
    // Words received
    output logic            rx_valid_o,
    output logic [DATA_W-1:0] rx_data_o,
    // Transaction status
    output logic            out_of_order_o
);
    function automatic logic [4:0] ones16(input logic [GROUP_W-1:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < GROUP_W; i++) begin
            n = n + {4'h0, v[i]};
        end
        return n;
    endfunction : ones16

    // Pin synchronisers; first stage feeds the second only
    sbdp_pins_t pins_s1;
    sbdp_pins_t pins_s2;
    sbdp_pins_t pins_d;
    logic       bclk_s1;
    logic       bclk_s2;
    logic       bclk_d;
    logic       out_of_order_indication_s1;
    logic       out_of_order_indication_s2;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_s1  <= PINS_IDLE;
            pins_s2  <= PINS_IDLE;
            pins_d   <= PINS_IDLE;
            bclk_s1  <= 1'b0;
            bclk_s2  <= 1'b0;
            bclk_d   <= 1'b0;
            out_of_order_indication_s1 <= PIN_IDLE;
            out_of_order_indication_s2 <= PIN_IDLE;
        end else begin
            pins_s1  <= pins_i;
            pins_s2  <= pins_s1;
            pins_d   <= pins_s2;
            bclk_s1  <= bus_clk_i;
            bclk_s2  <= bclk_s1;
            bclk_d   <= bclk_s2;
            out_of_order_indication_s1 <= out_of_order_indication_n_i;
            out_of_order_indication_s2 <= out_of_order_indication_s1;
        end
    end

    logic       bclk_rise;
    logic [3:0] phase;

    assign bclk_rise = bclk_s2 & ~bclk_d;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= PHASE_MAX;
        end else if (bclk_rise) begin
            phase <= 4'h0;
        end else if (phase != PHASE_MAX) begin
            phase <= phase + 4'h1;
        end
    end

    // Transmit buffer: the bus side stalls by inserting idle clocks
    logic       buf_valid;
    logic       buf_pop;
    sbdp_word_t buf_word;

    sbdp_buf u_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (tx_ready_o),
        .in_data_i   (tx_word_i),
        .out_valid_o (buf_valid),
        .out_ready_i (buf_pop),
        .out_data_o  (buf_word)
    );

    sbdp_tx_state_t state;
    sbdp_tx_state_t next_state;
    logic           sending;
    logic           other_owns;

    assign other_owns = ~pins_s2.data_bus_owned_n;

    always_comb begin
        next_state = state;
        case (state)
            TX_IDLE: begin
                if (bclk_rise && buf_valid && !other_owns) begin
                    next_state = TX_OWN; // R8
                end
            end
            TX_OWN: begin
                if (bclk_rise) begin
                    next_state = TX_DATA;
                end
            end
            TX_DATA: begin
                if (bclk_rise && buf_valid && buf_word.last) begin
                    next_state = TX_DONE;
                end
            end
            TX_DONE: begin
                if (bclk_rise) begin
                    next_state = TX_IDLE;
                end
            end
            default: begin
                next_state = TX_IDLE;
            end
        endcase
    end

    assign buf_pop = (state == TX_DATA) & bclk_rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= TX_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Pin drive; one word per bus clock keeps the strobe timing simple
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_o    <= PINS_IDLE;
            pins_oe_o <= 1'b0;
            sending   <= 1'b0;
        end else begin
            if (state == TX_IDLE && next_state == TX_OWN) begin
                pins_oe_o                <= 1'b1;
                pins_o.data_bus_owned_n  <= 1'b0; // R8
            end
            if (state == TX_DONE && bclk_rise) begin
                pins_oe_o                <= 1'b0;
                pins_o                   <= PINS_IDLE; // R8
            end
            // One strobe per popped word, in the bus clock after its pop; the closing bus clock strobes the last word
            if (phase == STB_RISE_CYC) begin
                sending <= 1'b0;
            end
            if (buf_pop) begin
                sending                      <= buf_valid;
                // Empty buffer gives an idle clock
                pins_o.data_valid_handshake_n <= ~buf_valid; // R3 R4
                for (int g = 0; g < GROUPS; g++) begin
                    if (ones16(buf_word.data[g*GROUP_W +: GROUP_W]) > INV_LIMIT) begin
                        pins_o.data_n[g*GROUP_W +: GROUP_W] <=
                            buf_word.data[g*GROUP_W +: GROUP_W]; // R7
                        pins_o.group_inversion_bits_n[g] <= 1'b0; // R5
                    end else begin
                        pins_o.data_n[g*GROUP_W +: GROUP_W] <=
                            ~buf_word.data[g*GROUP_W +: GROUP_W];
                        pins_o.group_inversion_bits_n[g] <= 1'b1;
                    end
                end
            end
            if (sending && phase == STB_FALL_CYC) begin
                pins_o.negative_data_strobes_n <= '0; // R5 R6
            end
            if (phase == STB_RISE_CYC) begin
                pins_o.negative_data_strobes_n <= '1;
            end
        end
    end

    // Receive: each group latched on either strobe's fall while in TX_IDLE and data-ready holds
    logic [3:0]        rx_mask;
    logic [DATA_W-1:0] rx_hold;
    logic              rx_take;
    logic [3:0]        stb_fall;

    assign rx_take  = (state == TX_IDLE) & ~pins_s2.data_valid_handshake_n; // R4
    assign stb_fall = (pins_d.negative_data_strobes_n & ~pins_s2.negative_data_strobes_n)
                    | (pins_d.positive_data_strobes_n & ~pins_s2.positive_data_strobes_n); // R6

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_mask    <= MASK_NONE;
            rx_hold    <= '0;
            rx_valid_o <= 1'b0;
            rx_data_o  <= '0;
        end else begin
            logic [3:0]        next_mask;
            logic [DATA_W-1:0] next_hold;
            next_mask  = rx_mask;
            next_hold  = rx_hold;
            rx_valid_o <= 1'b0;
            if (rx_take) begin
                for (int g = 0; g < GROUPS; g++) begin
                    if (stb_fall[g]) begin
                        next_mask[g] = 1'b1; // R5
                        next_hold[g*GROUP_W +: GROUP_W] =
                            pins_s2.group_inversion_bits_n[g]
                            ? ~pins_s2.data_n[g*GROUP_W +: GROUP_W]
                            :  pins_s2.data_n[g*GROUP_W +: GROUP_W]; // R7
                    end
                end
            end
            if (next_mask == MASK_FULL) begin
                rx_valid_o <= 1'b1;
                rx_data_o  <= next_hold;
                rx_mask    <= MASK_NONE;
            end else begin
                rx_mask    <= next_mask;
            end
            rx_hold <= next_hold;
        end
    end

    // Deferral is sampled on the bus clock, as the other agent drives it there
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_of_order_o <= 1'b0;
        end else if (bclk_rise) begin
            out_of_order_o <= ~out_of_order_indication_s2; // R1
        end
    end

    // Checks
    own_drive_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        (state == TX_DATA) |-> (pins_oe_o && !pins_o.data_bus_owned_n))
        else $error("data driven without bus ownership");
    own_release_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        (state == TX_DONE && bclk_rise) |=> (!pins_oe_o && pins_o.data_bus_owned_n))
        else $error("bus not released after last word");
    no_grab_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        (state == TX_IDLE && other_owns) |=> (state == TX_IDLE))
        else $error("bus taken while another agent owns it");
    ready_word_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        (buf_pop && buf_valid) |=> !pins_o.data_valid_handshake_n)
        else $error("data-ready missing on transfer");
    idle_clock_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        (buf_pop && !buf_valid) |=> (pins_o.data_valid_handshake_n
            && pins_o.negative_data_strobes_n == 4'hf) [*8])
        else $error("strobe or data-ready in idle clock");
    strobe_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        (sending && phase == STB_FALL_CYC && !bclk_rise)
            |=> (pins_o.negative_data_strobes_n == 4'h0) [*4]
            ##1 (pins_o.negative_data_strobes_n == 4'hf))
        else $error("negative strobe pulse malformed");
    inv_rule_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        !pins_o.data_valid_handshake_n |->
            (ones16(~pins_o.data_n[15:0]) <= INV_LIMIT
          && (pins_o.group_inversion_bits_n[0] || ones16(~pins_o.data_n[15:0]) < INV_LIMIT)))
        else $error("inversion bit inconsistent with group");
    rx_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        rx_valid_o |-> (!$past(pins_s2.data_valid_handshake_n) && $past(state) == TX_IDLE))
        else $error("word taken without data-ready");
    out_of_order_indication_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        (bclk_rise && !out_of_order_indication_s2) |=> out_of_order_o)
        else $error("deferral not reported");

    tx_burst_c: cover property (@(posedge clk_i) disable iff (rst_i)
        state == TX_DONE ##1 state == TX_IDLE);
    tx_stall_c: cover property (@(posedge clk_i) disable iff (rst_i)
        buf_pop && !buf_valid);
    rx_word_c:  cover property (@(posedge clk_i) disable iff (rst_i) rx_valid_o);
    out_of_order_indication_c:    cover property (@(posedge clk_i) disable iff (rst_i) $rose(out_of_order_o));
endmodule : sbdp_ctrl

// file: sim/sbdp_far_agent.sv
// Behavioural far-side bus agent: sends strobed words, decodes the device's words
`timescale 1ns/1ns
module sbdp_far_agent
    import sbdp_pkg::*;
(
    // Clock and wired bus level
    input  wire logic        clk_i,
    input  wire sbdp_pins_t  bus_i,
    // Levels this agent drives
    output sbdp_pins_t       drive_o,
    // Decoded device words
    output logic             mon_valid_o,
    output logic [DATA_W-1:0] mon_data_o,
    output logic [3:0]       mon_inv_n_o,
    output logic             mon_owned_n_o
);
    logic [3:0] prev_stb_n;
    initial begin
        drive_o     = PINS_IDLE;
        mon_valid_o = 1'b0;
        prev_stb_n  = 4'hf;
    end
    // Send one word; hs low models an idle clock with strobes but no data-ready
    task automatic send_word(input logic [DATA_W-1:0] w, input logic hs, input logic use_pos);
        logic [3:0] inv;
        for (int g = 0; g < GROUPS; g++) begin
            inv[g] = ($countones(w[16*g +: 16]) > 8);
        end
        @(posedge clk_i) #1;
        drive_o.data_n                 = w ^ ~{{16{inv[3]}}, {16{inv[2]}}, {16{inv[1]}}, {16{inv[0]}}};
        drive_o.group_inversion_bits_n = ~inv;
        drive_o.data_valid_handshake_n = ~hs;
        drive_o.data_bus_owned_n       = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        if (use_pos) drive_o.positive_data_strobes_n = 4'h0;
        else         drive_o.negative_data_strobes_n = 4'h0;
        repeat (4) @(posedge clk_i);
        #1;
        drive_o.positive_data_strobes_n = 4'hf;
        drive_o.negative_data_strobes_n = 4'hf;
        repeat (4) @(posedge clk_i);
        #1;
        // Released lines fall back to their termination level
        drive_o = PINS_IDLE;
    endtask : send_word
    // Device words are latched where its negative strobes fall
    always @(posedge clk_i) begin
        mon_valid_o <= 1'b0;
        prev_stb_n  <= bus_i.negative_data_strobes_n;
        if (prev_stb_n == 4'hf && bus_i.negative_data_strobes_n == 4'h0
            && bus_i.data_valid_handshake_n == 1'b0 && drive_o.data_valid_handshake_n) begin
            mon_valid_o   <= 1'b1;
            mon_inv_n_o   <= bus_i.group_inversion_bits_n;
            mon_owned_n_o <= bus_i.data_bus_owned_n;
            for (int g = 0; g < GROUPS; g++) begin
                mon_data_o[16*g +: 16] <= bus_i.group_inversion_bits_n[g]
                    ? ~bus_i.data_n[16*g +: 16] : bus_i.data_n[16*g +: 16];
            end
        end
    end
endmodule : sbdp_far_agent

// file: sim/tb_top.sv
// Self-checking bench of the data-phase control against a queue model
`timescale 1ns/1ns
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin bad_count++; $display("MISMATCH t=%0t %s", $time, m); end end
module tb_top;
    import sbdp_pkg::*;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              bus_clk = 1'b0;
    logic              out_of_order_indication_n = 1'b1;
    logic              tx_valid = 1'b0;
    sbdp_word_t        tx_word = '0;
    logic              tx_ready, rx_valid, out_of_order, pins_oe, mon_valid, mon_owned_n;
    logic [DATA_W-1:0] rx_data, mon_data;
    logic [3:0]        mon_inv_n;
    sbdp_pins_t        pins_out, far_pins, bus;
    int                bad_count = 0;
    int                check_count = 0;
    int                rx_seen = 0;
    logic [31:0]       seed = 32'hb3085451;
    logic [DATA_W-1:0] rx_q[$];
    logic [DATA_W-1:0] tx_q[$];
    logic [DATA_W-1:0] pat[6];
    always #4 clk_i = ~clk_i;
    always #40 bus_clk = ~bus_clk;
    // Open-drain style wiring: any low driver wins
    assign bus = sbdp_pins_t'(far_pins & (pins_oe ? pins_out : PINS_IDLE));
    sbdp_ctrl dut (
        .clk_i(clk_i), .rst_i(rst_i), .bus_clk_i(bus_clk),
        .out_of_order_indication_n_i(out_of_order_indication_n), .pins_i(bus), .pins_o(pins_out),
        .pins_oe_o(pins_oe), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
        .tx_word_i(tx_word), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .out_of_order_o(out_of_order)
    );
    sbdp_far_agent far (
        .clk_i(clk_i), .bus_i(bus), .drive_o(far_pins), .mon_valid_o(mon_valid),
        .mon_data_o(mon_data), .mon_inv_n_o(mon_inv_n), .mon_owned_n_o(mon_owned_n)
    );
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [DATA_W-1:0] rnd64();
        logic [DATA_W-1:0] r;
        for (int i = 0; i < DATA_W; i++) begin
            seed = lfsr(seed);
            r[i] = seed[0];
        end
        return r;
    endfunction : rnd64
    function automatic logic [3:0] exp_inv_n(input logic [DATA_W-1:0] w);
        logic [3:0] r;
        for (int g = 0; g < GROUPS; g++) r[g] = !($countones(w[16*g +: 16]) > 8);
        return r;
    endfunction : exp_inv_n
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    // Receive and transmit side model
    always @(posedge clk_i) begin
        if (rx_valid === 1'b1) begin
            rx_seen++;
            if (rx_q.size() == 0) `CHK(1'b1, 1'b0, "unexpected rx word")
            else `CHK(rx_data, rx_q.pop_front(), "rx data")
        end
        if (mon_valid === 1'b1) begin
            if (tx_q.size() == 0) `CHK(1'b1, 1'b0, "unexpected tx word")
            else begin
                `CHK(mon_inv_n, exp_inv_n(tx_q[0]), "tx inversion")
                `CHK(mon_data, tx_q.pop_front(), "tx data")
                `CHK(mon_owned_n, 1'b0, "bus busy during data")
            end
        end
    end
    initial begin
        #200000;
        bad_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        final_report();
    end
    initial begin
        logic saw_full;
        int   n;
        pat[0] = 64'h0000_0000_0000_0000;
        pat[1] = 64'hffff_ffff_ffff_ffff;
        pat[2] = 64'h01ff_00ff_01fe_ff00;
        for (int i = 3; i < 6; i++) pat[i] = rnd64();
        tick(20);
        rst_i = 1'b0;
        tick(1);
        `CHK(pins_oe, 1'b0, "reset oe")
        `CHK(pins_out, PINS_IDLE, "reset pins")
        `CHK(tx_ready, 1'b1, "reset ready")
        `CHK(out_of_order, 1'b0, "reset deferral")
        $display("test reset done");
        out_of_order_indication_n = 1'b0;
        tick(30);
        `CHK(out_of_order, 1'b1, "deferral seen")
        out_of_order_indication_n = 1'b1;
        tick(30);
        `CHK(out_of_order, 1'b0, "deferral cleared")
        $display("test deferral done");
        for (int i = 0; i < 6; i++) begin
            rx_q.push_back(pat[i]);
            far.send_word(pat[i], 1'b1, i[0]);
        end
        tick(10);
        `CHK(rx_q.size(), 0, "rx words missing")
        n = rx_seen;
        far.send_word(rnd64(), 1'b0, 1'b0);
        tick(10);
        `CHK(rx_seen, n, "idle clock took data")
        $display("test receive done");
        saw_full = 1'b0;
        for (int i = 0; i < 6; i++) begin
            tx_valid = 1'b1;
            tx_word  = '{last: (i == 5), data: pat[5 - i]};
            tx_q.push_back(pat[5 - i]);
            n = 0;
            while (tx_ready !== 1'b1 && n < 200) begin
                saw_full = 1'b1;
                tick(1);
                n++;
            end
            tick(1);
        end
        tx_valid = 1'b0;
        `CHK(saw_full, 1'b1, "buffer never refused")
        n = 0;
        while (tx_q.size() != 0 && n < 2000) begin
            tick(1);
            n++;
        end
        `CHK(tx_q.size(), 0, "tx words missing")
        tick(40);
        `CHK(pins_oe, 1'b0, "bus not released")
        `CHK(pins_out, PINS_IDLE, "pins not idle")
        $display("test transmit done");
        // A burst with a gap: the device must insert idle clocks
        tx_valid = 1'b1;
        tx_word  = '{last: 1'b0, data: pat[3]};
        tx_q.push_back(pat[3]);
        `CHK(tx_ready, 1'b1, "ready on empty buffer")
        tick(1);
        tx_valid = 1'b0;
        tick(60);
        `CHK(tx_q.size(), 0, "word before idle clocks missing")
        tx_valid = 1'b1;
        tx_word  = '{last: 1'b1, data: pat[4]};
        tx_q.push_back(pat[4]);
        tick(1);
        tx_valid = 1'b0;
        tick(60);
        `CHK(tx_q.size(), 0, "word after idle clocks missing")
        `CHK(pins_oe, 1'b0, "bus not released after stall")
        `CHK(pins_out, PINS_IDLE, "pins not idle after stall")
        $display("test transmit stall done");
        final_report();
    end
endmodule : tb_top
